/* File: osd_defines.vh */
/*
 * shared constants for the on-screen display serial receiver and pin block.
 * assumes it is included by bare name into the modules that use it.
 */
// Contract
// - lock the internal dot timing to the falling edge of the horizontal sync
// - take vertical sync as an active-low pulse on its own input
// - spi variant takes data only while select is low; high ends transfer
// - sample serial data on each rising edge of the serial clock
// - select bit clear: pin high inside windows except over characters
// - select bit set: pin gives a 50/50 clock locked to horizontal sync
// - pwm clock is 32 times line rate at 320 dots, 48 at 480
// - fast blank high over characters and windows, or characters only
// - fast blank is released when nothing is shown and after reset
// - colour outputs active high, released while display is disabled
// - once loaded, the screen refreshes itself; host sends only changes
// - memory writes never collide with the refresh reads
// - character height programmable from 16 to 63 scan lines
// - answer slave address 7a by default, changed only by a build option
// - start plus address byte; on match pull data low in ninth clock
// - each later byte is eight data bits plus one acknowledge bit
// - nothing received is shown until the display enable bit is set
// - bit 7 set means row address; clear means column, bit 6 auto mode
// - auto mode advances row and column after each data byte; code steps the column each byte, the row only on wrap past column 1f
`ifndef OSD_DEFINES_VH
`define OSD_DEFINES_VH

// serial link
`define OSD_SLAVE_ADDR 7'h7a
`define OSD_BYTE_BITS 4'h8
`define OSD_ROW_BIT 7
`define OSD_AUTO_BIT 6
`define OSD_ROW_MSB 3
`define OSD_COL_MSB 4
`define OSD_COL_LAST 5'h1f

// buffering
`define OSD_FIFO_DEPTH 8
`define OSD_FIFO_AW 3

// display timing
`define OSD_DOTS_LO 16'h0140
`define OSD_DOTS_HI 16'h01e0
`define OSD_DOTS_PER_PWM_HALF 3'h4
`define OSD_CHAR_H_MIN 6'h10
`define OSD_CHAR_H_MAX 6'h3f

`endif

/* File: osd_fifo.v */
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock and an already synchronised active-low reset.
 */
`timescale 1ns/1ps
module osd_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// flags from the fill count
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and count
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // osd_fifo

/* File: osd_top.v */
/*
 * serial receiver, memory write port and output pin control of the
 * on-screen display: two-wire slave (or spi variant), byte decoder with
 * auto-increment, sync-locked dot and pwm timing, and the pixel pins.
 * assumes the display engine supplies pixel and window levels on core_clk
 * and the control registers drive the mode bits on core_clk.
 */
`timescale 1ns/1ps
`include "osd_defines.vh"
module osd_top #(
	parameter SPI_VARIANT = 0,
	parameter [6:0] SLAVE_ADDR = `OSD_SLAVE_ADDR,
	parameter FIFO_DEPTH = `OSD_FIFO_DEPTH,
	parameter FIFO_AW = `OSD_FIFO_AW
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// serial pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire ss_in_n,
	// sync pins
	input wire hsync_in_n,
	input wire vsync_in_n,
	// control bits
	input wire display_enable,
	input wire pwm_clock_select,
	input wire blank_chars_only,
	input wire res_480,
	input wire [5:0] char_height,
	// display engine
	input wire refresh_busy,
	input wire char_pixel,
	input wire win_active,
	input wire [2:0] rgb_pixel,
	// memory write port
	output wire mem_wr_en,
	output wire [3:0] mem_wr_row,
	output wire [4:0] mem_wr_col,
	output wire [7:0] mem_wr_data,
	// timing outputs
	output wire dot_tick,
	output wire frame_start,
	output wire [5:0] char_line,
	// pixel pins
	output wire halftone_out,
	output wire fast_blank_out,
	output wire fast_blank_oe,
	output wire [2:0] rgb_out,
	output wire rgb_oe
);
	localparam RX_IDLE = 6'h01;
	localparam RX_ADDR = 6'h02;
	localparam RX_AACK = 6'h04;
	localparam RX_DATA = 6'h08;
	localparam RX_DACK = 6'h10;
	localparam RX_IGN = 6'h20;
	localparam DC_ADDR = 4'h1;
	localparam DC_COL = 4'h2;
	localparam DC_INFO = 4'h4;
	localparam DC_AUTO = 4'h8;

	reg rst_s1_reg;
	reg rst_n_reg;
	reg [1:0] scl_s_reg;
	reg [1:0] sda_s_reg;
	reg [1:0] ss_s_reg;
	reg [1:0] hs_s_reg;
	reg [1:0] vs_s_reg;
	reg scl_d_reg;
	reg sda_d_reg;
	reg hs_d_reg;
	reg vs_d_reg;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	wire hs_fall;
	wire vs_fall;

	// reset release through two flops
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	// pin synchronisers and delayed copies for edge finding
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			scl_s_reg <= 2'h3;
			sda_s_reg <= 2'h3;
			ss_s_reg <= 2'h3;
			hs_s_reg <= 2'h3;
			vs_s_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			hs_d_reg <= 1'b1;
			vs_d_reg <= 1'b1;
		end else begin
			scl_s_reg <= {scl_s_reg[0], scl_in};
			sda_s_reg <= {sda_s_reg[0], sda_in};
			ss_s_reg <= {ss_s_reg[0], ss_in_n};
			hs_s_reg <= {hs_s_reg[0], hsync_in_n};
			vs_s_reg <= {vs_s_reg[0], vsync_in_n};
			scl_d_reg <= scl_s_reg[1];
			sda_d_reg <= sda_s_reg[1];
			hs_d_reg <= hs_s_reg[1];
			vs_d_reg <= vs_s_reg[1];
		end
	end

	// edge and bus condition detection
	assign scl_rise = scl_s_reg[1] & ~scl_d_reg;
	assign scl_fall = ~scl_s_reg[1] & scl_d_reg;
	assign bus_start = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
	assign bus_stop = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];
	assign hs_fall = hs_d_reg & ~hs_s_reg[1];
	assign vs_fall = vs_d_reg & ~vs_s_reg[1];

	reg [5:0] rx_state_reg;
	reg [7:0] shift_reg;
	reg [3:0] bit_cnt_reg;
	reg first_reg;
	reg sda_oe_reg;
	reg push_valid_reg;
	reg [8:0] push_data_reg;
	wire fifo_in_ready;
	wire [7:0] shift_next;

	assign shift_next = {shift_reg[6:0], sda_s_reg[1]};

	// serial receiver: two-wire slave or spi variant
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rx_state_reg <= RX_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			first_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			push_valid_reg <= 1'b0;
			push_data_reg <= 9'h000;
		end else begin
			push_valid_reg <= 1'b0;
			if (SPI_VARIANT != 0) begin
				sda_oe_reg <= 1'b0;
				if (ss_s_reg[1]) begin
					bit_cnt_reg <= 4'h0;
					first_reg <= 1'b1;
				end else if (scl_rise) begin
					shift_reg <= shift_next;
					if (bit_cnt_reg == `OSD_BYTE_BITS - 4'h1) begin
						bit_cnt_reg <= 4'h0;
						first_reg <= 1'b0;
						push_valid_reg <= fifo_in_ready;
						push_data_reg <= {first_reg, shift_next};
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
			end else if (bus_start) begin
				rx_state_reg <= RX_ADDR;
				bit_cnt_reg <= 4'h0;
				first_reg <= 1'b1;
				sda_oe_reg <= 1'b0;
			end else if (bus_stop) begin
				rx_state_reg <= RX_IDLE;
				sda_oe_reg <= 1'b0;
			end else begin
				case (rx_state_reg)
				RX_ADDR, RX_DATA: begin
					if (scl_rise) begin
						shift_reg <= shift_next;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == `OSD_BYTE_BITS) begin
						if (rx_state_reg == RX_ADDR) begin
							// write address match only
							if (shift_reg[7:1] == SLAVE_ADDR && !shift_reg[0]) begin
								sda_oe_reg <= 1'b1;
								rx_state_reg <= RX_AACK;
							end else begin
								rx_state_reg <= RX_IGN;
							end
						end else begin
							// full fifo answers with no acknowledge
							sda_oe_reg <= fifo_in_ready;
							push_valid_reg <= fifo_in_ready;
							push_data_reg <= {first_reg, shift_reg};
							first_reg <= first_reg & ~fifo_in_ready;
							rx_state_reg <= RX_DACK;
						end
					end
				end
				RX_AACK, RX_DACK: begin
					if (scl_fall) begin
						sda_oe_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						rx_state_reg <= RX_DATA;
					end
				end
				RX_IGN: begin
					sda_oe_reg <= 1'b0;
				end
				RX_IDLE: begin
					sda_oe_reg <= 1'b0;
				end
				default: begin
					rx_state_reg <= RX_IDLE;
					sda_oe_reg <= 1'b0;
				end
				endcase
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_reg;

	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [8:0] fifo_out_data;

	// writes wait while refresh owns the memory
	assign fifo_out_ready = ~refresh_busy;

	osd_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(core_clk),
		.rst_n(rst_n_reg),
		.in_valid(push_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(push_data_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	reg [3:0] dc_state_reg;
	reg [3:0] row_reg;
	reg [4:0] col_reg;
	reg wr_en_reg;
	reg [3:0] wr_row_reg;
	reg [4:0] wr_col_reg;
	reg [7:0] wr_data_reg;
	wire [7:0] rx_byte;
	wire [3:0] dc_cur;

	assign rx_byte = fifo_out_data[7:0];
	// a new transfer always begins with an address
	assign dc_cur = fifo_out_data[8] ? DC_ADDR : dc_state_reg;

	// byte decoder and memory write port
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dc_state_reg <= DC_ADDR;
			row_reg <= 4'h0;
			col_reg <= 5'h00;
			wr_en_reg <= 1'b0;
			wr_row_reg <= 4'h0;
			wr_col_reg <= 5'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_en_reg <= 1'b0;
			if (fifo_out_valid && fifo_out_ready) begin
				case (dc_cur)
				DC_ADDR, DC_COL: begin
					if (rx_byte[`OSD_ROW_BIT]) begin
						row_reg <= rx_byte[`OSD_ROW_MSB:0];
						dc_state_reg <= DC_COL;
					end else begin
						col_reg <= rx_byte[`OSD_COL_MSB:0];
						dc_state_reg <= rx_byte[`OSD_AUTO_BIT] ? DC_AUTO : DC_INFO;
					end
				end
				DC_INFO, DC_AUTO: begin
					wr_en_reg <= 1'b1;
					wr_row_reg <= row_reg;
					wr_col_reg <= col_reg;
					wr_data_reg <= rx_byte;
					if (dc_cur == DC_AUTO) begin
						if (col_reg == `OSD_COL_LAST) begin
							col_reg <= 5'h00;
							row_reg <= row_reg + 4'h1;
						end else begin
							col_reg <= col_reg + 5'h01;
						end
						dc_state_reg <= DC_AUTO;
					end else begin
						dc_state_reg <= DC_ADDR;
					end
				end
				default: begin
					dc_state_reg <= DC_ADDR;
				end
				endcase
			end
		end
	end

	assign mem_wr_en = wr_en_reg;
	assign mem_wr_row = wr_row_reg;
	assign mem_wr_col = wr_col_reg;
	assign mem_wr_data = wr_data_reg;

	reg [15:0] line_cnt_reg;
	reg [15:0] period_reg;
	reg [15:0] acc_reg;
	reg dot_tick_reg;
	reg [2:0] dot_div_reg;
	reg pwm_level_reg;
	wire [15:0] dots_per_line;
	wire [16:0] acc_sum;

	assign dots_per_line = res_480 ? `OSD_DOTS_HI : `OSD_DOTS_LO;
	assign acc_sum = {1'b0, acc_reg} + {1'b0, dots_per_line};

	// dot timing locked to the falling edge of horizontal sync
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			line_cnt_reg <= 16'h0000;
			period_reg <= 16'h0000;
			acc_reg <= 16'h0000;
			dot_tick_reg <= 1'b0;
			dot_div_reg <= 3'h0;
			pwm_level_reg <= 1'b0;
		end else begin
			dot_tick_reg <= 1'b0;
			if (hs_fall) begin
				period_reg <= line_cnt_reg + 16'h0001;
				line_cnt_reg <= 16'h0000;
				// sync cycle is the first step, so a line ends on its last dot
				acc_reg <= dots_per_line;
				dot_div_reg <= 3'h0;
				pwm_level_reg <= 1'b1;
			end else begin
				if (line_cnt_reg != 16'hffff) begin
					line_cnt_reg <= line_cnt_reg + 16'h0001;
				end
				if (period_reg != 16'h0000) begin
					if (acc_sum >= {1'b0, period_reg}) begin
						acc_reg <= acc_sum[15:0] - period_reg;
						dot_tick_reg <= 1'b1;
						// five dots per half period: 64 or 96 halves a line
						if (dot_div_reg == `OSD_DOTS_PER_PWM_HALF) begin
							dot_div_reg <= 3'h0;
							pwm_level_reg <= ~pwm_level_reg;
						end else begin
							dot_div_reg <= dot_div_reg + 3'h1;
						end
					end else begin
						acc_reg <= acc_sum[15:0];
					end
				end
			end
		end
	end

	assign dot_tick = dot_tick_reg;

	reg [5:0] char_line_reg;
	reg frame_start_reg;
	wire [5:0] height_eff;

	// clamp the programmed height into its legal span
	assign height_eff = (char_height < `OSD_CHAR_H_MIN) ?
		`OSD_CHAR_H_MIN : char_height;

	// scan line within a character row, restarted by vertical sync
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			char_line_reg <= 6'h00;
			frame_start_reg <= 1'b0;
		end else begin
			frame_start_reg <= vs_fall;
			if (vs_fall) begin
				char_line_reg <= 6'h00;
			end else if (hs_fall) begin
				if (char_line_reg >= height_eff - 6'h01) begin
					char_line_reg <= 6'h00;
				end else begin
					char_line_reg <= char_line_reg + 6'h01;
				end
			end
		end
	end

	assign frame_start = frame_start_reg;
	assign char_line = char_line_reg;

	reg halftone_reg;
	reg fast_blank_oe_reg;
	reg [2:0] rgb_reg;
	reg rgb_oe_reg;

	// output pins, gated by display enable except the halftone pwm clock
	always @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			halftone_reg <= 1'b0;
			fast_blank_oe_reg <= 1'b0;
			rgb_reg <= 3'h0;
			rgb_oe_reg <= 1'b0;
		end else begin
			if (pwm_clock_select) begin
				halftone_reg <= pwm_level_reg;
			end else begin
				halftone_reg <= display_enable & win_active & ~char_pixel;
			end
			fast_blank_oe_reg <= display_enable &
				(char_pixel | (win_active & ~blank_chars_only));
			rgb_reg <= display_enable ? rgb_pixel : 3'h0;
			rgb_oe_reg <= display_enable;
		end
	end

	assign halftone_out = halftone_reg;
	assign fast_blank_out = fast_blank_oe_reg;
	assign fast_blank_oe = fast_blank_oe_reg;
	assign rgb_out = rgb_reg;
	assign rgb_oe = rgb_oe_reg;
endmodule // osd_top

/* File: osd_top_chk.sv */
/* assertions on the osd_top pins.
   assumes one core_clk domain and nrst as its reset. */
`timescale 1ns/1ps
module osd_top_chk (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// serial and control
	input wire sda_out,
	input wire sda_oe,
	input wire vsync_in_n,
	input wire display_enable,
	input wire pwm_clock_select,
	input wire blank_chars_only,
	input wire refresh_busy,
	input wire char_pixel,
	input wire win_active,
	input wire [2:0] rgb_pixel,
	// outputs
	input wire mem_wr_en,
	input wire frame_start,
	input wire halftone_out,
	input wire fast_blank_out,
	input wire fast_blank_oe,
	input wire [2:0] rgb_out,
	input wire rgb_oe
);
	reg [2:0] live_cnt_reg;
	wire live;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// edges since release; logic runs from the third
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			live_cnt_reg <= 3'h0;
		else if (live_cnt_reg != 3'h4)
			live_cnt_reg <= live_cnt_reg + 3'h1;
	end
	assign live = (live_cnt_reg == 3'h4);
	property p_mem_gap;
		mem_wr_en |-> !$past(refresh_busy);
	endproperty
	a_mem_gap: assert property (p_mem_gap) else $error("write in refresh");
	property p_fb_level;
		fast_blank_out == fast_blank_oe;
	endproperty
	a_fb_level: assert property (p_fb_level) else $error("blank level");
	property p_fb_sel;
		live && display_enable |=> fast_blank_oe == ($past(char_pixel)
			|| ($past(win_active) && !$past(blank_chars_only)));
	endproperty
	a_fb_sel: assert property (p_fb_sel) else $error("blank select");
	property p_dark;
		live && !display_enable |=> !fast_blank_oe && !rgb_oe;
	endproperty
	a_dark: assert property (p_dark) else $error("shown while off");
	property p_rgb;
		live |=> rgb_oe == $past(display_enable)
			&& (!rgb_oe || rgb_out == $past(rgb_pixel));
	endproperty
	a_rgb: assert property (p_rgb) else $error("colour pins");
	property p_halftone;
		live && display_enable && !pwm_clock_select |=>
			halftone_out == ($past(win_active) && !$past(char_pixel));
	endproperty
	a_halftone: assert property (p_halftone) else $error("halftone");
	property p_ack_line;
		sda_oe |-> !sda_out;
	endproperty
	a_ack_line: assert property (p_ack_line) else $error("ack level");
	property p_ack_hold;
		$rose(sda_oe) |-> sda_oe [*8] ##[1:30] !sda_oe;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack length");
	property p_frame;
		$fell(vsync_in_n) |-> ##[2:6] frame_start;
	endproperty
	a_frame: assert property (p_frame) else $error("no frame start");
	c_write: cover property (mem_wr_en);
	c_ack: cover property ($rose(sda_oe));
	c_pwm: cover property (pwm_clock_select && $rose(halftone_out));
endmodule // osd_top_chk

bind osd_top osd_top_chk chk (.core_clk, .nrst, .sda_out, .sda_oe,
	.vsync_in_n, .display_enable, .pwm_clock_select, .blank_chars_only,
	.refresh_busy, .char_pixel, .win_active, .rgb_pixel, .mem_wr_en,
	.frame_start, .halftone_out, .fast_blank_out, .fast_blank_oe,
	.rgb_out, .rgb_oe);

/* File: osd_host_model.sv */
/* host model: two-wire bus master writing to the display.
   assumes the bench resolves the pulled-up data line. */
`timescale 1ns/1ps
module osd_host_model (
	// clock
	input wire core_clk,
	// bus pins
	output logic scl,
	output logic sda_low,
	input wire sda_line
);
	// quarter of a 160 ns bit; far above the line rate limit to keep the
	// run short, the receiver only needs half periods over five clocks
	task automatic quarter();
		repeat (4) @(posedge core_clk);
	endtask
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data falls while the clock is high
	task automatic start_cond();
		sda_low <= 1'b1;
		quarter();
		scl <= 1'b0;
		quarter();
	endtask
	// msb first, data moves only with the clock low, ninth bit released
	task automatic write_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= (i > 0) ? ~b[i-1] : 1'b0;
			quarter();
			scl <= 1'b1;
			quarter();
			ack = ~sda_line;
			quarter();
			scl <= 1'b0;
			quarter();
		end
	endtask
	// data rises while the clock is high
	task automatic stop_cond();
		sda_low <= 1'b1;
		quarter();
		scl <= 1'b1;
		quarter();
		sda_low <= 1'b0;
		quarter();
	endtask
endmodule // osd_host_model

/* File: tb_osd_host_serial_and_output_pins.sv */
/* bench for osd_top: host model on the serial pins, stimulus on sync
   and engine pins, memory writes collected from the write port. */
`timescale 1ns/1ps
module tb_osd_host_serial_and_output_pins;
	logic core_clk, nrst, scl, sda_low, sda_line, sda_out, sda_oe;
	logic hsync_in_n, vsync_in_n, display_enable, pwm_clock_select;
	logic blank_chars_only, res_480, refresh_busy, char_pixel, win_active;
	logic mem_wr_en, dot_tick, halftone_out, fast_blank_out, fast_blank_oe;
	logic rgb_oe;
	logic [5:0] char_height, char_line;
	logic [2:0] rgb_pixel, rgb_out;
	logic [3:0] mem_wr_row;
	logic [4:0] mem_wr_col;
	logic [7:0] mem_wr_data;
	logic [16:0] wr_q [$];
	int err_count = 0;
	int n_compared = 0;
	// pulled-up data line
	assign sda_line = !(sda_low || (sda_oe && !sda_out));
	osd_host_model host (.core_clk, .scl, .sda_low, .sda_line);
	osd_top uut (.core_clk, .nrst, .scl_in(scl), .sda_in(sda_line),
		.sda_out, .sda_oe, .ss_in_n(1'b1), .hsync_in_n, .vsync_in_n,
		.display_enable, .pwm_clock_select, .blank_chars_only, .res_480,
		.char_height, .refresh_busy, .char_pixel, .win_active, .rgb_pixel,
		.mem_wr_en, .mem_wr_row, .mem_wr_col, .mem_wr_data, .dot_tick,
		.frame_start(), .char_line, .halftone_out, .fast_blank_out,
		.fast_blank_oe, .rgb_out, .rgb_oe);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// every write, packed row, column, data
	always @(posedge core_clk)
		if (mem_wr_en === 1'b1)
			wr_q.push_back({mem_wr_row, mem_wr_col, mem_wr_data});
	task automatic check_val(input logic [16:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bounded wait for the next write, then compare it
	task automatic expect_wr(input logic [16:0] exp);
		for (int i = 0; i < 300 && wr_q.size() == 0; i++)
			@(posedge core_clk);
		if (wr_q.size() == 0) begin
			err_count++;
			$display("wrong value at %0t: write missing", $time);
			print_verdict();
		end else begin
			check_val(wr_q.pop_front(), exp, "memory write");
		end
	endtask
	// one transfer; stops at the first missing ack
	task automatic xfer(input logic [7:0] pk [$], input int busy_at,
		output int n);
		logic a;
		n = 0;
		host.start_cond();
		foreach (pk[i]) begin
			if (i == busy_at)
				refresh_busy <= 1'b1;
			host.write_byte(pk[i], a);
			if (a !== 1'b1)
				break;
			n++;
		end
		host.stop_cond();
	endtask
	task automatic t_write();
		int n;
		xfer('{8'hf4, 8'h83, 8'h05, 8'h41, 8'h07, 8'h42}, -1, n);
		check_val(17'(n), 17'h6, "acks");
		expect_wr({4'h3, 5'h05, 8'h41});
		expect_wr({4'h3, 5'h07, 8'h42});
	endtask
	// auto mode from the last column wraps to the next row
	task automatic t_auto();
		int n;
		xfer('{8'hf4, 8'h82, 8'h5f, 8'h11, 8'h22, 8'h33}, -1, n);
		check_val(17'(n), 17'h6, "acks");
		expect_wr({4'h2, 5'h1f, 8'h11});
		expect_wr({4'h3, 5'h00, 8'h22});
		expect_wr({4'h3, 5'h01, 8'h33});
	endtask
	// foreign address, then own address with read bit
	task automatic t_foreign();
		int n;
		xfer('{8'hf6, 8'h83, 8'h05, 8'h41}, -1, n);
		check_val(17'(n), 17'h0, "foreign ack");
		xfer('{8'hf5, 8'h83}, -1, n);
		check_val(17'(n), 17'h0, "read ack");
		repeat (50) @(posedge core_clk);
		check_val(17'(wr_q.size()), 17'h0, "stray write");
	endtask
	// refresh holds memory: buffer fills and refuses, then drains
	task automatic t_stall();
		int n;
		xfer('{8'hf4, 8'h81, 8'h40, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
			8'h06, 8'h07, 8'h08, 8'h09, 8'h0a}, 3, n);
		check_val(17'(n), 17'hb, "refusal");
		check_val(17'(wr_q.size()), 17'h0, "write in refresh");
		refresh_busy <= 1'b0;
		for (int k = 0; k < n - 3; k++)
			expect_wr({4'h1, 5'(k), 8'(k + 1)});
	endtask
	// every enable, blank mode, character and window combination
	task automatic t_pins();
		logic [3:0] v;
		logic fb, ht;
		for (int k = 0; k < 16; k++) begin
			v = 4'(k);
			fb = v[3] && (v[1] || (v[0] && !v[2]));
			ht = v[3] && v[0] && !v[1];
			@(posedge core_clk);
			{display_enable, blank_chars_only, char_pixel, win_active} <= v;
			rgb_pixel <= 3'(k);
			@(posedge core_clk);
			#1;
			check_val(17'(fast_blank_oe), 17'(fb), "blank");
			check_val(17'(fast_blank_out), 17'(fb), "blank pin");
			check_val(17'(halftone_out), 17'(ht), "halftone");
			check_val(17'(rgb_oe), 17'(v[3]), "colour on");
			if (v[3])
				check_val(17'(rgb_out), 17'(k[2:0]), "colour");
		end
	endtask
	// one 960-cycle line with counts of ticks and pwm edges
	task automatic run_line(input logic vs, output int t, r, h);
		logic prev;
		t = 0;
		r = 0;
		h = 0;
		prev = halftone_out;
		for (int c = 0; c < 960; c++) begin
			@(posedge core_clk);
			hsync_in_n <= (c >= 40);
			vsync_in_n <= !(vs && c < 40);
			#1;
			t += (dot_tick === 1'b1);
			r += (halftone_out === 1'b1 && prev === 1'b0);
			h += (halftone_out === 1'b1);
			prev = halftone_out;
		end
	endtask
	task automatic t_pwm();
		int t, r, h;
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk);
			res_480 <= m[0];
			pwm_clock_select <= 1'b1;
			for (int l = 0; l < 4; l++)
				run_line(l == 0, t, r, h);
			check_val(17'(t), m ? 17'h1e0 : 17'h140, "dots");
			check_val(17'(r), m ? 17'h30 : 17'h20, "pwm edges");
			check_val(17'(h), 17'h1e0, "pwm duty");
		end
		pwm_clock_select <= 1'b0;
	endtask
	// short lines; a height below the span counts as sixteen lines
	task automatic t_height();
		char_height <= 6'h05;
		for (int l = 0; l < 17; l++) begin
			repeat (4) @(posedge core_clk);
			hsync_in_n <= 1'b0;
			vsync_in_n <= (l != 0);
			repeat (4) @(posedge core_clk);
			hsync_in_n <= 1'b1;
			vsync_in_n <= 1'b1;
			repeat (8) @(posedge core_clk);
			check_val(17'(char_line), (l == 16) ? 17'h0 : 17'(l), "line");
		end
	endtask
	initial begin
		nrst = 1'b0;
		{hsync_in_n, vsync_in_n, display_enable, pwm_clock_select} = 4'hc;
		{blank_chars_only, res_480, refresh_busy} = 3'h0;
		{char_pixel, win_active, rgb_pixel} = 5'h00;
		char_height = 6'h20;
		#1;
		check_val(17'({sda_oe, fast_blank_oe, rgb_oe}), 17'h0, "reset");
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge core_clk);
		t_write();
		t_auto();
		t_foreign();
		t_stall();
		t_pins();
		t_pwm();
		t_height();
		print_verdict();
	end
endmodule // tb_osd_host_serial_and_output_pins
